// ==== logic/command_status_regs.sv ====
// Command and status register with overrun counter and soft reset
// Assumes a synchronous register port and an external list engine
//
// Notes on behaviour
// - Each scheduling overrun increments the two-bit count at bits 17:16.
// - Count resets to zero and wraps from three back to zero.
// - Count increments even when the overrun event flag is already set.
// - Setting ownership request bit 3 sets ownership change flag bit 30.
// - Ownership request clears after changeover and stays clear.
// - At bulk head: skip if bit clear, else clear it and process.
// - Descriptor found in bulk list re-sets bulk filled bit.
// - At control head: skip if bit clear, else clear and process.
// - Descriptor found in control list re-sets control filled bit.
// - Reset bit 0 forces suspend and resets registers except exempt ones.
// - No host bus accesses while the software reset is in progress.
// - Software reset completes within 10 us, then its bit self-clears.
// - Software reset leaves root hub and downstream ports untouched.
// - Writes set bits written one and leave zero bits unchanged.
// - Periodic list unfinished at end of frame is an overrun.
// - Reads return every current bit, including counter and commands.
`include "cmd_status_regs.svh"
module command_status_regs #(
  parameter int SRST_DONE = `SRST_DONE_CYCLES
) (
  input  wire logic                     clk_in,
  input  wire logic                     rst_n_in,
  input  wire cmd_status_pkg::reg_req_t req_in,
  output logic [31:0]                   rdata_out,
  output logic                          rvalid_out,
  input  wire logic                     end_of_frame_in,
  input  wire logic                     periodic_busy_in,
  input  wire logic                     changeover_done_in,
  input  wire logic                     bulk_start_in,
  input  wire logic                     bulk_td_found_in,
  input  wire logic                     ctrl_start_in,
  input  wire logic                     ctrl_td_found_in,
  output logic                          bulk_process_out,
  output logic                          ctrl_process_out,
  output logic                          overrun_event_out,
  output logic                          ownership_event_out,
  output logic                          soft_reset_out,
  output logic                          suspend_enter_out,
  output logic                          bus_master_en_out
);
  // Request edge to bit clear takes SRST_DONE + 1 cycles
  if (SRST_DONE < 1 || SRST_DONE > `SRST_CYCLES - 1) begin
    $error("SRST_DONE must finish the soft reset within 10 us");
  end

  logic       rst_meta_r;
  logic       rst_sync_r;
  logic [1:0] overrun_count_r;
  logic       own_req_r;
  logic       reset_req_r;
  logic [9:0] srst_cnt_r;
  cmd_status_pkg::srst_state_t srst_state_r;
  logic       bulk_flag;
  logic       ctrl_flag;
  logic       wr_hit;
  logic       overrun;
  logic       srst_clear;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign wr_hit = req_in.valid & req_in.write
                & (req_in.addr == `CSR_OFFSET);
  assign overrun = end_of_frame_in & periodic_busy_in;
  assign srst_clear = (srst_state_r == cmd_status_pkg::ST_RESET);

  // Overrun count: cleared by soft reset, counts regardless of flag
  always_ff @(posedge clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      overrun_count_r <= 2'h0;
    end else if (srst_clear) begin
      overrun_count_r <= 2'h0;
    end else if (overrun) begin
      overrun_count_r <= overrun_count_r + 2'h1;
    end
  end

  assign overrun_event_out = overrun & ~srst_clear;

  // Ownership request: write-one-to-set, set wins over changeover clear
  always_ff @(posedge clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      own_req_r <= 1'b0;
    end else if (wr_hit && req_in.wdata[`CSR_OCR_BIT]) begin
      own_req_r <= 1'b1;
    end else if (srst_clear || changeover_done_in) begin
      own_req_r <= 1'b0;
    end
  end

  assign ownership_event_out = wr_hit & req_in.wdata[`CSR_OCR_BIT];

  list_filled_flag u_bulk (
    .clk_in        (clk_in),
    .rst_n_in      (rst_sync_r),
    .clr_in        (srst_clear),
    .sw_set_in     (wr_hit & req_in.wdata[`CSR_BLF_BIT]),
    .list_start_in (bulk_start_in),
    .td_found_in   (bulk_td_found_in),
    .flag_out      (bulk_flag),
    .process_out   (bulk_process_out)
  );

  list_filled_flag u_ctrl (
    .clk_in        (clk_in),
    .rst_n_in      (rst_sync_r),
    .clr_in        (srst_clear),
    .sw_set_in     (wr_hit & req_in.wdata[`CSR_CLF_BIT]),
    .list_start_in (ctrl_start_in),
    .td_found_in   (ctrl_td_found_in),
    .flag_out      (ctrl_flag),
    .process_out   (ctrl_process_out)
  );

  // Soft reset sequencer
  always_ff @(posedge clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      srst_state_r <= cmd_status_pkg::ST_RUN;
      srst_cnt_r   <= 10'h000;
      reset_req_r  <= 1'b0;
    end else begin
      unique case (srst_state_r)
        cmd_status_pkg::ST_RUN: begin
          if (wr_hit && req_in.wdata[`CSR_SRR_BIT]) begin
            reset_req_r  <= 1'b1;
            srst_state_r <= cmd_status_pkg::ST_RESET;
            srst_cnt_r   <= 10'h000;
          end
        end
        cmd_status_pkg::ST_RESET: begin
          srst_cnt_r <= srst_cnt_r + 10'h001;
          if (srst_cnt_r == 10'(SRST_DONE - 1)) begin
            srst_state_r <= cmd_status_pkg::ST_DONE;
          end
        end
        cmd_status_pkg::ST_DONE: begin
          reset_req_r  <= 1'b0;
          srst_state_r <= cmd_status_pkg::ST_RUN;
        end
        default: srst_state_r <= cmd_status_pkg::ST_RUN;
      endcase
    end
  end

  // Root hub and port resets are not driven from here
  assign soft_reset_out    = srst_clear;
  assign suspend_enter_out = (srst_state_r == cmd_status_pkg::ST_DONE);
  assign bus_master_en_out = ~reset_req_r;

  always_ff @(posedge clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      rdata_out  <= `CSR_RESET_VALUE;
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= req_in.valid & ~req_in.write;
      rdata_out  <= 32'h0000_0000;
      if (req_in.valid && !req_in.write
          && req_in.addr == `CSR_OFFSET) begin
        rdata_out[`CSR_SOC_HI:`CSR_SOC_LO] <= overrun_count_r;
        rdata_out[`CSR_OCR_BIT] <= own_req_r;
        rdata_out[`CSR_BLF_BIT] <= bulk_flag;
        rdata_out[`CSR_CLF_BIT] <= ctrl_flag;
        rdata_out[`CSR_SRR_BIT] <= reset_req_r;
      end
    end
  end

  a_count_step: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
    overrun && !srst_clear |=> overrun_count_r
      == $past(overrun_count_r) + 2'h1)
    else $error("overrun count did not step");
  a_count_wrap: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
    overrun && !srst_clear && overrun_count_r == 2'h3
      |=> overrun_count_r == 2'h0)
    else $error("overrun count did not wrap");
  a_own_event: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
    ownership_event_out |=> own_req_r)
    else $error("ownership request not held");
  a_own_clear: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
    changeover_done_in && !wr_hit |=> !own_req_r)
    else $error("ownership request not cleared");
  a_bulk_skip: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
    bulk_start_in && !bulk_flag |-> !bulk_process_out)
    else $error("bulk list processed while empty");
  a_bulk_rearm: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
    bulk_td_found_in && !srst_clear |=> bulk_flag)
    else $error("bulk flag not rearmed");
  a_ctrl_take: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
    ctrl_process_out && !ctrl_td_found_in && !wr_hit |=> !ctrl_flag)
    else $error("control flag not taken");
  a_srst_bound: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
    $rose(reset_req_r) |-> ##[1:500] !reset_req_r)
    else $error("soft reset exceeded limit");
  a_srst_quiet: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
    reset_req_r |-> !bus_master_en_out)
    else $error("bus access during soft reset");
  a_srst_state: assert property (@(posedge clk_in) disable iff (!rst_sync_r)
    srst_clear |-> overrun_count_r == 2'h0 || $past(srst_clear) == 1'b0)
    else $error("registers not cleared by soft reset");

  c_overrun_wrap: cover property (@(posedge clk_in)
    overrun && overrun_count_r == 2'h3);
  c_soft_reset: cover property (@(posedge clk_in) suspend_enter_out);
  c_bulk_run: cover property (@(posedge clk_in)
    bulk_process_out ##1 bulk_td_found_in);
  c_own_change: cover property (@(posedge clk_in)
    ownership_event_out ##[1:20] changeover_done_in);
endmodule

// ==== logic/list_filled_flag.sv ====
// One list-filled flag: software sets, list engine clears and re-arms
// Assumes one clock and synchronous strobes
module list_filled_flag (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic clr_in,
  input  wire logic sw_set_in,
  input  wire logic list_start_in,
  input  wire logic td_found_in,
  output logic      flag_out,
  output logic      process_out
);
  // Process the list only when the flag was set at head
  assign process_out = list_start_in & flag_out;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_out <= 1'b0;
    end else if (clr_in) begin
      flag_out <= 1'b0;
    end else if (sw_set_in || td_found_in) begin
      flag_out <= 1'b1;
    end else if (list_start_in) begin
      flag_out <= 1'b0;
    end
  end
endmodule

// ==== shared/cmd_status_pkg.sv ====
// Types shared by the command and status logic
// Assumes nothing of its surroundings
package cmd_status_pkg;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_RESET = 3'b010,
    ST_DONE  = 3'b100
  } srst_state_t;
endpackage

// ==== shared/cmd_status_regs.svh ====
// Offsets, field positions, reset values and timing counts
// Assumes a 50 MHz controller clock
`ifndef CMD_STATUS_REGS_SVH
`define CMD_STATUS_REGS_SVH
`define CSR_OFFSET          8'h08
`define CSR_RESET_VALUE     32'h0000_0000
`define CSR_SRR_BIT         0
`define CSR_CLF_BIT         1
`define CSR_BLF_BIT         2
`define CSR_OCR_BIT         3
`define CSR_SOC_LO          16
`define CSR_SOC_HI          17
`define EVT_SO_BIT          0
`define EVT_OC_BIT          30
`define CLK_PERIOD_NS       20
`define SRST_LIMIT_NS       10000
`define SRST_CYCLES         (`SRST_LIMIT_NS / `CLK_PERIOD_NS)
`define SRST_DONE_CYCLES    16
`endif

// ==== sim/ohci_command_status_logic_tb.sv ====
// Self-checking bench for the command and status register block
// Assumes the package, the header and the design files are compiled first
module ohci_command_status_logic_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic                     clk_in = 1'b0;
  logic                     rst_n_in = 1'b0;
  cmd_status_pkg::reg_req_t req = '0;
  logic [31:0]              rdata;
  logic                     rvalid, eof = 0, pbusy = 0, cdone = 0;
  logic [1:0]               st = '0, td = '0, proc;
  logic                     ovf, own, srst, susp, bmen;
  int                       err_count = 0;
  int                       num_checks = 0;

  command_status_regs #(.SRST_DONE(2)) DUT (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req),
    .rdata_out(rdata), .rvalid_out(rvalid),
    .end_of_frame_in(eof), .periodic_busy_in(pbusy),
    .changeover_done_in(cdone),
    .bulk_start_in(st[1]), .bulk_td_found_in(td[1]),
    .ctrl_start_in(st[0]), .ctrl_td_found_in(td[0]),
    .bulk_process_out(proc[1]), .ctrl_process_out(proc[0]),
    .overrun_event_out(ovf), .ownership_event_out(own),
    .soft_reset_out(srst), .suspend_enter_out(susp),
    .bus_master_en_out(bmen)
  );

  always #10 clk_in = ~clk_in;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick;
    @(posedge clk_in);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    tick();
    req = '{1'b1, 1'b1, a, d};
    tick();
    req = '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    tick();
    req = '{1'b1, 1'b0, a, 32'h0000_0000};
    tick();
    req = '0;
    chk({31'h0, rvalid}, 32'h1);
    chk(rdata, exp);
  endtask

  task automatic test_map;
    rd(8'h08, 32'h0000_0000);
    wr(8'h0C, 32'h0000_000F);
    rd(8'h0C, 32'h0000_0000);
    rd(8'h08, 32'h0000_0000);
  endtask

  // Ctrl flag is bit 1 on lane 0, bulk flag bit 2 on lane 1
  task automatic test_lists;
    for (int i = 0; i < 2; i++) begin
      wr(8'h08, 32'h1 << (i + 1));
      wr(8'h08, 32'h0000_0000);
      rd(8'h08, 32'h1 << (i + 1));
      st[i] = 1'b1;
      #1 chk({31'h0, proc[i]}, 32'h1);
      tick();
      st[i] = 1'b0;
      rd(8'h08, 32'h0000_0000);
      st[i] = 1'b1;
      #1 chk({31'h0, proc[i]}, 32'h0);
      tick();
      st[i] = 1'b0;
      td[i] = 1'b1;
      tick();
      td[i] = 1'b0;
      rd(8'h08, 32'h1 << (i + 1));
      st[i] = 1'b1;
      tick();
      st[i] = 1'b0;
    end
    wr(8'h08, 32'h0000_0002);
    wr(8'h08, 32'h0000_0004);
    rd(8'h08, 32'h0000_0006);
    st = 2'b11;
    tick();
    st = 2'b00;
  endtask

  task automatic test_owner;
    logic seen;
    req = '{1'b1, 1'b1, 8'h08, 32'h0000_0008};
    #1 seen = own;
    tick();
    seen = seen | own;
    req = '0;
    chk({31'h0, seen}, 32'h1);
    rd(8'h08, 32'h0000_0008);
    cdone = 1'b1;
    tick();
    cdone = 1'b0;
    rd(8'h08, 32'h0000_0000);
    rd(8'h08, 32'h0000_0000);
  endtask

  task automatic test_overrun;
    pbusy = 1'b1;
    for (int n = 1; n <= 5; n++) begin
      eof = 1'b1;
      #1 chk({31'h0, ovf}, 32'h1);
      tick();
      eof = 1'b0;
      rd(8'h08, (n % 4) << 16);
    end
    pbusy = 1'b0;
    eof = 1'b1;
    #1 chk({31'h0, ovf}, 32'h0);
    tick();
    eof = 1'b0;
    rd(8'h08, 32'h0001_0000);
  endtask

  task automatic test_soft_reset;
    int n;
    wr(8'h08, 32'h0000_0006);
    wr(8'h08, 32'h0000_0001);
    chk({31'h0, srst}, 32'h1);
    chk({31'h0, bmen}, 32'h0);
    n = 0;
    while (susp !== 1'b1 && n < 500) begin
      tick();
      n++;
    end
    chk({31'h0, susp}, 32'h1);
    chk(n, 32'h0000_0002);
    tick();
    chk({31'h0, bmen}, 32'h1);
    rd(8'h08, 32'h0000_0000);
  endtask

  task automatic report_and_stop;
    if (err_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #50us;
    err_count++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    repeat (3) tick();
    test_map();
    test_lists();
    test_owner();
    test_overrun();
    test_soft_reset();
    report_and_stop();
  end
endmodule
